/* core/eic_params.svh */
`ifndef EIC_PARAMS_SVH
`define EIC_PARAMS_SVH

// register indices; byte address is four times the index
`define EIC_IDX_PC_FLAGS 8'h1B
`define EIC_IDX_EXT_FLAGS 8'h1C
`define EIC_IDX_EXT_MASK 8'h1D
`define EIC_IDX_PC_EN 8'h68
`define EIC_IDX_SENSE 8'h69
`define EIC_IDX_PC_MASK0 8'h6B
`define EIC_IDX_PC_MASK1 8'h6C
`define EIC_IDX_PC_MASK2 8'h6D
`define EIC_IDX_PC_MASK3 8'h73

// reset values
`define EIC_RST_EXT_MASK 3'h0
`define EIC_RST_SENSE 6'h00
`define EIC_RST_PC_EN 4'h0
`define EIC_RST_PC_MASK 32'h0000_0000

// field widths and positions
`define EIC_N_EXT 3
`define EIC_N_GRP 4
`define EIC_N_PC 32
`define EIC_ADDR_W 10
`define EIC_IDX_LSB 2

// sense-control codes
`define EIC_SENSE_LOW 2'h0
`define EIC_SENSE_ANY 2'h1
`define EIC_SENSE_FALL 2'h2
`define EIC_SENSE_RISE 2'h3

// bus responses
`define EIC_RESP_OKAY 2'h0
`define EIC_RESP_SLVERR 2'h2

`endif

/* core/eic_pkg.sv */
`include "eic_params.svh"

package eic_pkg;

    typedef struct packed {
        logic [`EIC_ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [`EIC_ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } eic_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } eic_axi_rsp_t;

    typedef struct packed {
        logic [`EIC_N_EXT-1:0] ext_s1;
        logic [`EIC_N_EXT-1:0] ext_s2;
        logic [`EIC_N_EXT-1:0] ext_prev;
        logic [`EIC_N_PC-1:0] pc_s1;
        logic [`EIC_N_PC-1:0] pc_s2;
        logic [`EIC_N_PC-1:0] pc_prev;
        logic [`EIC_N_EXT-1:0] ext_mask;
        logic [2*`EIC_N_EXT-1:0] sense;
        logic [`EIC_N_EXT-1:0] ext_flags;
        logic [`EIC_N_GRP-1:0] pc_en;
        logic [`EIC_N_GRP-1:0] pc_flags;
        logic [`EIC_N_PC-1:0] pc_mask;
        logic [`EIC_N_EXT-1:0] ext_req;
        logic [`EIC_N_GRP-1:0] pc_req;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_idx;
        logic [7:0] wbyte;
        logic wlane;
        eic_axi_rsp_t rsp;
    } eic_state_t;

endpackage

/* core/eic_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "eic_params.svh"

module eic_top import eic_pkg::*; (
    input wire logic clk_sys, // system clock, 50 MHz
    input wire logic rst, // synchronous reset, active high
    input wire eic_axi_req_t axi_req, // register bus, master side
    output eic_axi_rsp_t axi_rsp, // register bus, slave side
    input wire logic [`EIC_N_EXT-1:0] dedicated_irq_pins, // pad levels
    input wire logic [`EIC_N_PC-1:0] pin_change_inputs, // pad levels
    input wire logic global_irq_en, // global bit of core status register
    input wire logic io_clk_run, // I/O clock domain active
    input wire logic sleep_active, // core is in a sleep mode
    input wire logic [`EIC_N_EXT-1:0] ext_irq_ack, // routine entered, pulse
    input wire logic [`EIC_N_GRP-1:0] pc_irq_ack, // routine entered, pulse
    output logic [`EIC_N_EXT-1:0] ext_irq_req, // dedicated pin requests
    output logic [`EIC_N_GRP-1:0] pc_irq_req // change group requests
);

    eic_state_t q_q;
    eic_state_t st_d;

    logic [`EIC_N_EXT-1:0] ext_seen;
    logic [`EIC_N_EXT-1:0] ext_set;
    logic [`EIC_N_PC-1:0] pc_chg;
    logic [`EIC_N_GRP-1:0] pc_set;
    logic [`EIC_N_EXT-1:0] ext_level;

    // pads are sampled whatever their direction, so driving a pin
    // from software triggers like an outside source
    // a disabled pin's buffer is cut in sleep and reads low
    assign ext_seen = q_q.ext_s2 & ~({`EIC_N_EXT{sleep_active}}
        & ~q_q.ext_mask);

    genvar gi;
    generate
        for (gi = 0; gi < `EIC_N_EXT; gi++) begin : g_ext
            logic [1:0] mode;
            assign mode = q_q.sense[2*gi +: 2];
            assign ext_level[gi] = (mode == `EIC_SENSE_LOW);
            always_comb begin
                unique case (mode)
                    `EIC_SENSE_LOW: ext_set[gi] = 1'b0;
                    `EIC_SENSE_ANY:
                        ext_set[gi] = ext_seen[gi] ^ q_q.ext_prev[gi];
                    `EIC_SENSE_FALL:
                        ext_set[gi] = q_q.ext_prev[gi] & ~ext_seen[gi];
                    `EIC_SENSE_RISE:
                        ext_set[gi] = ~q_q.ext_prev[gi] & ext_seen[gi];
                endcase
            end
        end
        for (gi = 0; gi < `EIC_N_GRP; gi++) begin : g_grp
            assign pc_set[gi] = |pc_chg[8*gi +: 8];
        end
    endgenerate

    // prev only advances with the I/O clock, so a pin that toggles and
    // returns while it is stopped shows no change
    assign pc_chg = (q_q.pc_s2 ^ q_q.pc_prev) & q_q.pc_mask
        & {`EIC_N_PC{io_clk_run}};

    function automatic logic [8:0] read_reg(input eic_state_t s,
        input logic [7:0] idx);
        logic [8:0] r;
        r = {1'b1, 8'h00};
        unique case (idx)
            `EIC_IDX_EXT_MASK: r[7:0] = {5'h00, s.ext_mask};
            `EIC_IDX_SENSE: r[7:0] = {2'h0, s.sense};
            `EIC_IDX_EXT_FLAGS: r[7:0] = {5'h00, s.ext_flags};
            `EIC_IDX_PC_EN: r[7:0] = {4'h0, s.pc_en};
            `EIC_IDX_PC_FLAGS: r[7:0] = {4'h0, s.pc_flags};
            `EIC_IDX_PC_MASK0: r[7:0] = s.pc_mask[7:0];
            `EIC_IDX_PC_MASK1: r[7:0] = s.pc_mask[15:8];
            `EIC_IDX_PC_MASK2: r[7:0] = s.pc_mask[23:16];
            `EIC_IDX_PC_MASK3: r[7:0] = s.pc_mask[31:24];
            default: r = 9'h000;
        endcase
        return r;
    endfunction

    always_comb begin
        logic [`EIC_N_EXT-1:0] ext_w1c;
        logic [`EIC_N_GRP-1:0] pc_w1c;
        logic [8:0] rd;
        logic hit;
        ext_w1c = '0;
        pc_w1c = '0;
        rd = '0;
        hit = 1'b0;
        st_d = q_q;

        // two-stage synchronisers ahead of any flag logic
        // a pulse held over two clock edges is missed only on change inputs with the I/O clock stopped or on disabled pins in sleep
        // wake-up itself is the power controller's job
        st_d.ext_s1 = dedicated_irq_pins;
        st_d.ext_s2 = q_q.ext_s1;
        st_d.ext_prev = ext_seen;
        st_d.pc_s1 = pin_change_inputs;
        st_d.pc_s2 = q_q.pc_s1;
        if (io_clk_run) begin
            st_d.pc_prev = q_q.pc_s2;
        end

        // write channel: address and data in either order
        if (axi_req.awvalid && q_q.rsp.awready) begin
            st_d.aw_got = 1'b1;
            st_d.aw_idx = axi_req.awaddr[`EIC_IDX_LSB +: 8];
        end
        if (axi_req.wvalid && q_q.rsp.wready) begin
            st_d.w_got = 1'b1;
            st_d.wbyte = axi_req.wdata[7:0];
            st_d.wlane = axi_req.wstrb[0];
        end
        if (q_q.aw_got && q_q.w_got && !q_q.rsp.bvalid) begin
            hit = 1'b1;
            unique case (q_q.aw_idx)
                `EIC_IDX_EXT_MASK:
                    if (q_q.wlane) st_d.ext_mask = q_q.wbyte[2:0];
                `EIC_IDX_SENSE:
                    if (q_q.wlane) st_d.sense = q_q.wbyte[5:0];
                `EIC_IDX_EXT_FLAGS:
                    if (q_q.wlane) ext_w1c = q_q.wbyte[2:0];
                `EIC_IDX_PC_EN:
                    if (q_q.wlane) st_d.pc_en = q_q.wbyte[3:0];
                `EIC_IDX_PC_FLAGS:
                    if (q_q.wlane) pc_w1c = q_q.wbyte[3:0];
                `EIC_IDX_PC_MASK0:
                    if (q_q.wlane) st_d.pc_mask[7:0] = q_q.wbyte;
                `EIC_IDX_PC_MASK1:
                    if (q_q.wlane) st_d.pc_mask[15:8] = q_q.wbyte;
                `EIC_IDX_PC_MASK2:
                    if (q_q.wlane) st_d.pc_mask[23:16] = q_q.wbyte;
                `EIC_IDX_PC_MASK3:
                    if (q_q.wlane) st_d.pc_mask[31:24] = q_q.wbyte;
                default: hit = 1'b0;
            endcase
            st_d.aw_got = 1'b0;
            st_d.w_got = 1'b0;
            st_d.rsp.bvalid = 1'b1;
            st_d.rsp.bresp = hit ? `EIC_RESP_OKAY : `EIC_RESP_SLVERR;
        end
        if (q_q.rsp.bvalid && axi_req.bready) begin
            st_d.rsp.bvalid = 1'b0;
        end
        st_d.rsp.awready = !st_d.aw_got && !st_d.rsp.bvalid;
        st_d.rsp.wready = !st_d.w_got && !st_d.rsp.bvalid;

        // read channel
        if (q_q.rsp.rvalid && axi_req.rready) begin
            st_d.rsp.rvalid = 1'b0;
        end
        if (axi_req.arvalid && q_q.rsp.arready) begin
            rd = read_reg(q_q, axi_req.araddr[`EIC_IDX_LSB +: 8]);
            st_d.rsp.rvalid = 1'b1;
            st_d.rsp.rdata = {24'h000000, rd[7:0]};
            st_d.rsp.rresp = rd[8] ? `EIC_RESP_OKAY : `EIC_RESP_SLVERR;
        end
        st_d.rsp.arready = !st_d.rsp.rvalid;

        // a set in the same cycle as a clear wins
        st_d.ext_flags = (q_q.ext_flags & ~ext_w1c & ~ext_irq_ack)
            | ext_set;
        st_d.ext_flags = st_d.ext_flags & ~ext_level;
        st_d.pc_flags = (q_q.pc_flags & ~pc_w1c & ~pc_irq_ack)
            | pc_set;

        // level requests follow the synchronised pin with no latch,
        // so a level gone before start-up ends asks nothing
        // the driver must hold it long enough to be seen
        st_d.ext_req = {`EIC_N_EXT{global_irq_en}} & q_q.ext_mask
            & ((ext_level & ~ext_seen)
            | (~ext_level & q_q.ext_flags));
        st_d.pc_req = {`EIC_N_GRP{global_irq_en}} & q_q.pc_en
            & q_q.pc_flags;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q_q <= '0;
            q_q.ext_mask <= `EIC_RST_EXT_MASK;
            q_q.sense <= `EIC_RST_SENSE;
            q_q.pc_en <= `EIC_RST_PC_EN;
            q_q.pc_mask <= `EIC_RST_PC_MASK;
        end else begin
            q_q <= st_d;
        end
    end

    assign axi_rsp = q_q.rsp;
    assign ext_irq_req = q_q.ext_req;
    assign pc_irq_req = q_q.pc_req;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    generate
        for (gi = 0; gi < `EIC_N_EXT; gi++) begin : g_chk_ext
            level_flag_zero_a: assert property (
                q_q.sense[2*gi +: 2] == `EIC_SENSE_LOW
                |=> !q_q.ext_flags[gi])
                else $error("flag set while pin is level sensed");
            level_request_a: assert property (
                q_q.sense[2*gi +: 2] == `EIC_SENSE_LOW
                && q_q.ext_mask[gi] && global_irq_en && !ext_seen[gi]
                |=> ext_irq_req[gi])
                else $error("held low level gave no request");
            rise_sets_flag_a: assert property (
                q_q.sense[2*gi +: 2] == `EIC_SENSE_RISE
                && !q_q.ext_prev[gi] && ext_seen[gi]
                |=> q_q.ext_flags[gi])
                else $error("rising edge did not set flag");
            fall_only_a: assert property (
                q_q.sense[2*gi +: 2] == `EIC_SENSE_FALL
                && !q_q.ext_flags[gi] && !(q_q.ext_prev[gi]
                && !ext_seen[gi])
                |=> !q_q.ext_flags[gi])
                else $error("flag set without a falling edge");
            ext_gate_a: assert property (
                ext_irq_req[gi]
                |-> $past(global_irq_en) && $past(q_q.ext_mask[gi]))
                else $error("request without enable and global bit");
        end
        for (gi = 0; gi < `EIC_N_GRP; gi++) begin : g_chk_grp
            group_ack_clear_a: assert property (
                pc_irq_ack[gi] && !pc_set[gi] |=> !q_q.pc_flags[gi])
                else $error("acknowledged group flag not cleared");
            group_req_gate_a: assert property (
                pc_irq_req[gi] |-> $past(global_irq_en)
                && $past(q_q.pc_en[gi]) && $past(q_q.pc_flags[gi]))
                else $error("group request without enable");
        end
    endgenerate

    masked_change_a: assert property (
        io_clk_run && (q_q.pc_s2[7:0] != q_q.pc_prev[7:0])
        && ((q_q.pc_s2[7:0] ^ q_q.pc_prev[7:0]) & q_q.pc_mask[7:0])
        == 8'h00 && !q_q.pc_flags[0]
        |=> !q_q.pc_flags[0])
        else $error("masked input set group flag");

    io_clock_gate_a: assert property (
        !io_clk_run |=> (q_q.pc_flags & ~$past(q_q.pc_flags)) == 4'h0)
        else $error("group flag set while I/O clock stopped");

    sync_depth_a: assert property (
        $changed(pin_change_inputs) |-> ##2 q_q.pc_s2 ==
        $past(pin_change_inputs, 2))
        else $error("pin change not seen two cycles later");

    resp_hold_a: assert property (
        axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid
        && $stable(axi_rsp.bresp))
        else $error("write response dropped before taken");

endmodule

`default_nettype wire

/* test/eic_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module eic_core_model import eic_pkg::*; (
    input wire logic clk_sys, // system clock
    input wire logic rst, // synchronous reset
    input wire logic ack_on, // core enters routines
    input wire logic [2:0] ext_irq_req, // pin requests
    input wire logic [3:0] pc_irq_req, // group requests
    output logic [2:0] ext_irq_ack, // routine entered
    output logic [3:0] pc_irq_ack // routine entered
);
    // gap after each pulse so the flag can drop before the next one
    always_ff @(posedge clk_sys) begin
        if (rst || !ack_on) begin
            ext_irq_ack <= 3'h0;
            pc_irq_ack <= 4'h0;
        end else begin
            ext_irq_ack <= ext_irq_req & ~ext_irq_ack;
            pc_irq_ack <= pc_irq_req & ~pc_irq_ack;
        end
    end
endmodule
`default_nettype wire

/* test/eic_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "eic_params.svh"
module eic_top_bench import eic_pkg::*; ;
    localparam logic [7:0] FL = `EIC_IDX_EXT_FLAGS;
    localparam logic [7:0] MK = `EIC_IDX_EXT_MASK;
    localparam logic [7:0] SN = `EIC_IDX_SENSE;
    localparam logic [7:0] PF = `EIC_IDX_PC_FLAGS;
    localparam logic [7:0] PE = `EIC_IDX_PC_EN;
    logic [7:0] pcm [4] = '{`EIC_IDX_PC_MASK0, `EIC_IDX_PC_MASK1,
        `EIC_IDX_PC_MASK2, `EIC_IDX_PC_MASK3};
    logic [7:0] all_idx [9] = '{PF, FL, MK, PE, SN, `EIC_IDX_PC_MASK0,
        `EIC_IDX_PC_MASK1, `EIC_IDX_PC_MASK2, `EIC_IDX_PC_MASK3};
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    eic_axi_req_t axi_req = '0;
    eic_axi_rsp_t axi_rsp;
    logic [2:0] dpin = 3'h7;
    logic [31:0] pcin = 32'h0;
    logic glob = 1'h0;
    logic io_run = 1'h1;
    logic sleep = 1'h0;
    logic ack_on = 1'h0;
    logic [2:0] ext_ack;
    logic [2:0] ext_req;
    logic [3:0] pc_ack;
    logic [3:0] pc_req;
    logic [31:0] rdat;
    logic [1:0] rrsp;
    logic fe;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;

    eic_top uut (.clk_sys(clk_sys), .rst(rst), .axi_req(axi_req),
        .axi_rsp(axi_rsp), .dedicated_irq_pins(dpin),
        .pin_change_inputs(pcin), .global_irq_en(glob),
        .io_clk_run(io_run), .sleep_active(sleep), .ext_irq_ack(ext_ack),
        .pc_irq_ack(pc_ack), .ext_irq_req(ext_req), .pc_irq_req(pc_req));
    eic_core_model core (.clk_sys(clk_sys), .rst(rst), .ack_on(ack_on),
        .ext_irq_req(ext_req), .pc_irq_req(pc_req),
        .ext_irq_ack(ext_ack), .pc_irq_ack(pc_ack));

    always #10 clk_sys = ~clk_sys;

    task results;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // about 460 cycles are needed; a hang ends here
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            results();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
            input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // reads after an edge see the values sampled at that edge
    task automatic wr(input logic [7:0] idx, input logic [7:0] d,
            input logic [1:0] er);
        logic aw;
        logic w;
        aw = 1'h0;
        w = 1'h0;
        @(posedge clk_sys);
        axi_req.awaddr <= {idx, 2'h0};
        axi_req.awvalid <= 1'h1;
        axi_req.wdata <= {24'h0, d};
        axi_req.wstrb <= 4'hF;
        axi_req.wvalid <= 1'h1;
        while (!(aw && w)) begin
            @(posedge clk_sys);
            if (!aw && axi_rsp.awready === 1'h1) begin
                aw = 1'h1;
                axi_req.awvalid <= 1'h0;
            end
            if (!w && axi_rsp.wready === 1'h1) begin
                w = 1'h1;
                axi_req.wvalid <= 1'h0;
            end
        end
        // bready comes late so a waiting response must hold
        do @(posedge clk_sys); while (axi_rsp.bvalid !== 1'h1);
        axi_req.bready <= 1'h1;
        do @(posedge clk_sys); while (axi_rsp.bvalid !== 1'h1);
        axi_req.bready <= 1'h0;
        chk("write resp", {30'h0, er}, {30'h0, axi_rsp.bresp});
    endtask

    task automatic rd(input logic [7:0] idx);
        @(posedge clk_sys);
        axi_req.araddr <= {idx, 2'h0};
        axi_req.arvalid <= 1'h1;
        axi_req.rready <= 1'h1;
        do @(posedge clk_sys); while (axi_rsp.arready !== 1'h1);
        axi_req.arvalid <= 1'h0;
        do @(posedge clk_sys); while (axi_rsp.rvalid !== 1'h1);
        axi_req.rready <= 1'h0;
        rdat = axi_rsp.rdata;
        rrsp = axi_rsp.rresp;
    endtask

    task automatic rc(input string nm, input logic [7:0] idx,
            input logic [7:0] e);
        rd(idx);
        chk(nm, {24'h0, e}, rdat);
        chk("read resp", 32'h0, {30'h0, rrsp});
    endtask

    initial begin
        wt(10);
        rst <= 1'h0;
        foreach (all_idx[i]) rc("reset value", all_idx[i], 8'h00);
        wr(SN, 8'hFF, 2'h0);
        rc("sense reserved", SN, 8'h3F);
        wr(8'h00, 8'h5A, 2'h2);
        rd(8'h00);
        chk("unmapped data", 32'h0, rdat);
        chk("unmapped resp", 32'h2, {30'h0, rrsp});
        $display("test registers done");
        for (int c = 1; c < 4; c++) begin
            wr(MK, 8'h00, 2'h0);
            wr(SN, 8'(c), 2'h0);
            wr(FL, 8'h07, 2'h0);
            dpin[0] <= 1'h0;
            wt(6);
            fe = (c != 3);
            rc("flag after fall", FL, {7'h0, fe});
            dpin[0] <= 1'h1;
            wt(6);
            rc("flag after rise", FL, {7'h0, fe | (c != 2)});
            wr(FL, 8'h00, 2'h0);
            rc("flag after zero write", FL, 8'h01);
            wr(FL, 8'h01, 2'h0);
            rc("flag after clear", FL, 8'h00);
        end
        $display("test edge modes done");
        wr(SN, 8'h20, 2'h0);
        wr(FL, 8'h07, 2'h0);
        wr(MK, 8'h04, 2'h0);
        glob <= 1'h1;
        dpin[2] <= 1'h0;
        wt(6);
        chk("pin request", 32'h4, {29'h0, ext_req});
        glob <= 1'h0;
        wt(3);
        chk("request global off", 32'h0, {29'h0, ext_req});
        glob <= 1'h1;
        ack_on <= 1'h1;
        wt(6);
        chk("request after ack", 32'h0, {29'h0, ext_req});
        ack_on <= 1'h0;
        rc("flag after ack", FL, 8'h00);
        dpin[2] <= 1'h1;
        wr(MK, 8'h02, 2'h0);
        dpin[1] <= 1'h0;
        wt(6);
        chk("level request", 32'h2, {29'h0, ext_req});
        rc("level flag", FL, 8'h00);
        chk("level request held", 32'h2, {29'h0, ext_req});
        dpin[1] <= 1'h1;
        wt(6);
        chk("level released", 32'h0, {29'h0, ext_req});
        wr(MK, 8'h00, 2'h0);
        $display("test requests done");
        wr(PE, 8'h0F, 2'h0);
        foreach (pcm[g]) wr(pcm[g], 8'h01, 2'h0);
        for (int g = 0; g < 4; g++) begin
            pcin[8*g+1] <= 1'h1;
            wt(6);
            rc("masked input", PF, 8'h00);
            pcin[8*g] <= 1'h1;
            wt(6);
            rc("group flag", PF, 8'(1 << g));
            chk("group request", 32'(1 << g), {28'h0, pc_req});
            wr(PF, 8'(1 << g), 2'h0);
            rc("group flag cleared", PF, 8'h00);
        end
        wr(PE, 8'h00, 2'h0);
        pcin[0] <= 1'h0;
        wt(6);
        chk("group disabled", 32'h0, {28'h0, pc_req});
        rc("flag while disabled", PF, 8'h01);
        wr(PE, 8'h01, 2'h0);
        ack_on <= 1'h1;
        wt(6);
        ack_on <= 1'h0;
        rc("group flag after ack", PF, 8'h00);
        io_run <= 1'h0;
        wt(1);
        pcin[0] <= 1'h1;
        wt(4);
        pcin[0] <= 1'h0;
        wt(4);
        io_run <= 1'h1;
        wt(6);
        rc("io clock stopped", PF, 8'h00);
        $display("test pin change done");
        wr(SN, 8'h02, 2'h0);
        wr(FL, 8'h07, 2'h0);
        sleep <= 1'h1;
        wt(6);
        sleep <= 1'h0;
        rc("flag after sleep", FL, 8'h01);
        wr(SN, 8'h00, 2'h0);
        rc("level clears flag", FL, 8'h00);
        $display("test sleep done");
        results();
    end
endmodule
`default_nettype wire
